// [hw/asc_ctrl.sv]
/*
  Sequencing and result formatting of one converter: sampling start,
  conversion trigger, channel sequencing, completion flag, APB slave.
  Assumes an analogue core on pclk that takes a start pulse per channel
  and answers with conv_done and a 12-bit raw code.
*/
// Implementation choices: the placing of the registers and register access over APB.
// Operation
// - layout 11, 12-bit: left-justified, low nibble zero, top bit inverted.
// - layout 10, 12-bit: left-justified in bits 15..4, low nibble zero.
// - layout 01, 12-bit: right-justified, bits 15..11 inverse of bit 11.
// - layout 00, 12-bit: right-justified, bits 15..12 zero.
// - trigger 111: internal counter ends sampling and starts conversion.
// - trigger 100: timer five compare ends sampling.
// - trigger 010: timer three compare ends sampling.
// - trigger 001: external pin edge ends sampling.
// - trigger 000: only software clearing acquire_active ends sampling.
// - parallel with count 1x: channels zero to three sampled together.
// - parallel with count 01: channels zero and one sampled together.
// - parallel clear: channels held one after another.
// - wide resolution set: parallel bit unimplemented, reads zero.
// - auto restart: new sampling right after conversion, acquire set.
// - acquire_active set by hardware with auto restart; 1 sampling.
// - trigger not 000: hardware clears acquire_active at conversion.
// - complete flag set when conversion cycle finishes, else zero.
// - software may clear complete flag; writing one is ignored.
// - clearing complete flag does not disturb running work.
// - complete flag cleared when a new conversion begins.
`timescale 1ns/10ps
`include "asc_regs.svh"
module asc_ctrl #(
  parameter int AUTO_CYC = `ASC_AUTO_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`ASC_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic irq_zero_pin,
  input wire logic tmr3_cmp,
  input wire logic tmr5_cmp,
  output asc_pkg::asc_conv_s conv_req,
  input wire logic conv_done,
  input wire logic [11:0] conv_raw,
  output logic [3:0] sample_mask,
  output logic [15:0] result_word
);
  import asc_pkg::*;

  localparam int CW = $clog2(AUTO_CYC + 1);
  localparam logic [CW-1:0] CNT_LAST = CW'(AUTO_CYC - 1);

  asc_ctrl_s ctrl_q;
  asc_state_e state_q;
  logic [1:0] chn_q, chan_q, last_chan;
  logic acq_q, done_q;
  logic [CW-1:0] cnt_q;
  logic [15:0] result_q, ctrl_rd, fmt_word;
  logic [3:0] smask_q, act_mask;
  logic [31:0] prdata_q;
  logic [2:0] evt;
  logic acc, wr_ctrl, wr_chn, mapped, fire, start_acquire_active, finish, par_eff;

  // ----------------------------------------------------------------
  // trigger inputs: pin synchronised, timer compares on pclk already
  // ----------------------------------------------------------------
  asc_edge_det #(.SYNC(1'b1)) u_pin (
    .pclk(pclk),
    .presetn(presetn),
    .din(irq_zero_pin),
    .rise(evt[0])
  );
  asc_edge_det #(.SYNC(1'b0)) u_tmr3 (
    .pclk(pclk),
    .presetn(presetn),
    .din(tmr3_cmp),
    .rise(evt[1])
  );
  asc_edge_det #(.SYNC(1'b0)) u_tmr5 (
    .pclk(pclk),
    .presetn(presetn),
    .din(tmr5_cmp),
    .rise(evt[2])
  );

  // ----------------------------------------------------------------
  // apb decode: zero wait states, unmapped offsets flag pslverr
  // ----------------------------------------------------------------
  assign acc = psel & penable;
  assign mapped = (paddr == `ASC_OFF_CTRL) | (paddr == `ASC_OFF_CHAN) |
                  (paddr == `ASC_OFF_RES);
  assign wr_ctrl = acc & pwrite & (paddr == `ASC_OFF_CTRL);
  assign wr_chn = acc & pwrite & (paddr == `ASC_OFF_CHAN);
  assign pready = 1'b1;
  assign pslverr = acc & ~mapped;
  assign prdata = prdata_q;

  // parallel capture is absent in 12-bit mode
  assign par_eff = ctrl_q.par & ~ctrl_q.wide;
  assign ctrl_rd = {5'h00, ctrl_q.wide, ctrl_q.fmt, ctrl_q.trig, 1'b0,
                    par_eff, ctrl_q.auto_rs, acq_q, done_q};

  // read data is latched in the setup cycle so prdata leaves a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else if (psel & ~penable & ~pwrite) begin
      unique case (paddr)
        `ASC_OFF_CTRL: prdata_q <= {16'h0000, ctrl_rd};
        `ASC_OFF_CHAN: prdata_q <= {30'h0000_0000, chn_q};
        `ASC_OFF_RES: prdata_q <= {16'h0000, result_q};
        default: prdata_q <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // software fields
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= asc_ctrl_s'(`ASC_RST_CTRL);
      chn_q <= `ASC_RST_CHN;
    end else begin
      if (wr_ctrl) begin
        ctrl_q.wide <= pwdata[`ASC_B_WIDE];
        ctrl_q.fmt <= pwdata[`ASC_FMT_HI:`ASC_FMT_LO];
        ctrl_q.trig <= pwdata[`ASC_TRIG_HI:`ASC_TRIG_LO];
        ctrl_q.par <= pwdata[`ASC_B_PAR];
        ctrl_q.auto_rs <= pwdata[`ASC_B_AUTO];
      end
      if (wr_chn) begin
        chn_q <= pwdata[`ASC_CHN_HI:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // channel set from the count field
  // ----------------------------------------------------------------
  always_comb begin
    if (chn_q == `ASC_CHN_ONE) begin
      last_chan = `ASC_LAST_ONE;
      act_mask = 4'h1;
    end else if (chn_q == `ASC_CHN_TWO) begin
      last_chan = `ASC_LAST_TWO;
      act_mask = 4'h3;
    end else begin
      last_chan = `ASC_LAST_FOUR;
      act_mask = 4'hf;
    end
  end

  // ----------------------------------------------------------------
  // end-of-sampling trigger; reserved codes never fire
  // ----------------------------------------------------------------
  always_comb begin
    fire = 1'b0;
    if (state_q == ST_SAMPLE) begin
      case (ctrl_q.trig)
        `ASC_TRIG_SW: fire = wr_ctrl & ~pwdata[`ASC_B_ACQ];
        `ASC_TRIG_PIN: fire = evt[0];
        `ASC_TRIG_TMR3: fire = evt[1];
        `ASC_TRIG_TMR5: fire = evt[2];
        `ASC_TRIG_AUTO: fire = (cnt_q == CNT_LAST);
        default: fire = 1'b0;
      endcase
    end
  end

  // a software write of 1 starts sampling; auto restart starts by itself
  assign start_acquire_active = (state_q == ST_IDLE) &
                      (ctrl_q.auto_rs | (wr_ctrl & pwdata[`ASC_B_ACQ]));
  assign finish = (state_q == ST_WAIT) & conv_done & (chan_q == last_chan);

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_IDLE;
      chan_q <= 2'h0;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (start_acquire_active) begin
            state_q <= ST_SAMPLE;
          end
        end
        ST_SAMPLE: begin
          if (fire) begin
            state_q <= ST_START;
            chan_q <= 2'h0;
          end
        end
        ST_START: begin
          state_q <= ST_WAIT;
        end
        ST_WAIT: begin
          if (conv_done) begin
            if (chan_q != last_chan) begin
              chan_q <= chan_q + 2'h1;
              state_q <= ST_START;
            end else if (ctrl_q.auto_rs) begin
              state_q <= ST_SAMPLE;
            end else begin
              state_q <= ST_IDLE;
            end
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // auto-convert sample timer, restarted on every sampling phase
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= '0;
    end else if (state_q != ST_SAMPLE) begin
      cnt_q <= '0;
    end else if (cnt_q != CNT_LAST) begin
      cnt_q <= cnt_q + CW'(1);
    end
  end

  // ----------------------------------------------------------------
  // acquire_active mirrors the sampling phase
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acq_q <= 1'b0;
    end else if (fire) begin
      acq_q <= 1'b0;
    end else if (start_acquire_active | (finish & ctrl_q.auto_rs)) begin
      acq_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // complete flag: hardware set beats a software clear in one cycle
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_q <= 1'b0;
    end else if (finish) begin
      done_q <= 1'b1;
    end else if (fire) begin
      done_q <= 1'b0;
    end else if (wr_ctrl & ~pwdata[`ASC_B_DONE]) begin
      done_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // sample/hold: parallel mode holds all at once, otherwise in turn
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      smask_q <= 4'h0;
    end else if (start_acquire_active | (finish & ctrl_q.auto_rs)) begin
      smask_q <= act_mask;
    end else if (fire & par_eff) begin
      smask_q <= 4'h0;
    end else if (fire) begin
      smask_q <= smask_q & ~4'h1;
    end else if ((state_q == ST_WAIT) & conv_done & ~finish) begin
      smask_q <= smask_q & ~(4'h1 << (chan_q + 2'h1));
    end
  end

  assign sample_mask = smask_q;
  assign conv_req.start = (state_q == ST_START);
  assign conv_req.chan = chan_q;

  // ----------------------------------------------------------------
  // result layout
  // ----------------------------------------------------------------
  always_comb begin
    fmt_word = {6'h00, conv_raw[9:0]};
    if (ctrl_q.wide) begin
      unique case (ctrl_q.fmt)
        `ASC_FMT_SFRAC: fmt_word = {~conv_raw[11], conv_raw[10:0], 4'h0};
        `ASC_FMT_FRAC: fmt_word = {conv_raw, 4'h0};
        `ASC_FMT_SINT: fmt_word = {{5{~conv_raw[11]}}, conv_raw[10:0]};
        `ASC_FMT_INT: fmt_word = {4'h0, conv_raw};
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_q <= 16'h0000;
    end else if ((state_q == ST_WAIT) & conv_done) begin
      result_q <= fmt_word;
    end
  end

  assign result_word = result_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_cap(logic [1:0] f);
    (state_q == ST_WAIT) && conv_done && ctrl_q.wide && ctrl_q.fmt == f;
  endsequence
  property p_sfrac;
    s_cap(`ASC_FMT_SFRAC) |=> result_q == {~$past(conv_raw[11]), $past(conv_raw[10:0]), 4'h0};
  endproperty
  a_sfrac: assert property (p_sfrac) else $error("signed fraction wrong");
  property p_frac;
    s_cap(`ASC_FMT_FRAC) |=> result_q == {$past(conv_raw), 4'h0};
  endproperty
  a_frac: assert property (p_frac) else $error("fraction wrong");
  property p_sint;
    s_cap(`ASC_FMT_SINT) |=> result_q[15:11] == {5{~$past(conv_raw[11])}} &&
                    result_q[10:0] == $past(conv_raw[10:0]);
  endproperty
  a_sint: assert property (p_sint) else $error("signed integer wrong");
  property p_int;
    s_cap(`ASC_FMT_INT) |=> result_q == {4'h0, $past(conv_raw)};
  endproperty
  a_int: assert property (p_int) else $error("integer wrong");
  sequence s_auto_full;
    state_q == ST_SAMPLE && ctrl_q.trig == `ASC_TRIG_AUTO && cnt_q == CNT_LAST;
  endsequence
  property p_auto;
    s_auto_full |=> state_q == ST_START ##1 conv_req.start == 1'b0;
  endproperty
  a_auto: assert property (p_auto) else $error("auto convert missed");
  property p_swend;
    state_q == ST_SAMPLE && ctrl_q.trig == `ASC_TRIG_SW && wr_ctrl && !pwdata[`ASC_B_ACQ]
      |=> !acq_q && state_q == ST_START;
  endproperty
  a_swend: assert property (p_swend) else $error("sw end ignored");
  property p_hwclr;
    fire && ctrl_q.trig != `ASC_TRIG_SW |=> !acq_q && !done_q;
  endproperty
  a_hwclr: assert property (p_hwclr) else $error("acquire not cleared");
  property p_restart;
    finish && ctrl_q.auto_rs |=> acq_q && done_q && state_q == ST_SAMPLE;
  endproperty
  a_restart: assert property (p_restart) else $error("no restart");
  property p_noset;
    !done_q && !finish && wr_ctrl && pwdata[`ASC_B_DONE] |=> !done_q;
  endproperty
  a_noset: assert property (p_noset) else $error("sw set flag");
  // the read word itself, not the internal mux, must hide the parallel bit
  property p_par_rd;
    psel && !penable && !pwrite && paddr == `ASC_OFF_CTRL && ctrl_q.wide
      |=> !prdata[`ASC_B_PAR];
  endproperty
  a_par_rd: assert property (p_par_rd) else $error("parallel bit read");

endmodule

// [hw/asc_edge_det.sv]
/*
  Rising-edge detector with optional two-flop synchroniser.
  Assumes one clock; SYNC=1 for pins from outside the domain.
*/
`timescale 1ns/10ps
module asc_edge_det #(
  parameter bit SYNC = 1'b1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic din,
  output logic rise
);

  logic lvl;
  logic prev_q;

  // ----------------------------------------------------------------
  // optional synchroniser
  // ----------------------------------------------------------------
  generate
    if (SYNC) begin : g_sync
      logic s1_q;
      logic s2_q;
      // first flop feeds only the second
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          s1_q <= 1'b0;
          s2_q <= 1'b0;
        end else begin
          s1_q <= din;
          s2_q <= s1_q;
        end
      end
      assign lvl = s2_q;
    end else begin : g_direct
      assign lvl = din;
    end
  endgenerate

  // ----------------------------------------------------------------
  // edge
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_q <= 1'b0;
    end else begin
      prev_q <= lvl;
    end
  end

  assign rise = lvl & ~prev_q;

endmodule

// [hw/asc_pkg.sv]
/*
  Types shared by the converter sequencing control.
  Assumes asc_regs.svh is available on the include path.
*/
package asc_pkg;

  // sequencing states
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SAMPLE,
    ST_START,
    ST_WAIT
  } asc_state_e;

  // software control fields
  typedef struct packed {
    logic wide;
    logic [1:0] fmt;
    logic [2:0] trig;
    logic par;
    logic auto_rs;
  } asc_ctrl_s;

  // request to the analogue core
  typedef struct packed {
    logic start;
    logic [1:0] chan;
  } asc_conv_s;

endpackage

// [hw/asc_regs.svh]
/*
  Register map, field positions, codes and reset values of the
  converter sequencing control. Assumes a 32-bit APB with byte addresses.
*/
`ifndef ASC_REGS_SVH
`define ASC_REGS_SVH

// ----------------------------------------------------------------
// offsets
// ----------------------------------------------------------------
`define ASC_AW 8
`define ASC_OFF_CTRL 8'h00
`define ASC_OFF_CHAN 8'h04
`define ASC_OFF_RES 8'h08

// ----------------------------------------------------------------
// converter_control_one fields
// ----------------------------------------------------------------
`define ASC_B_DONE 0
`define ASC_B_ACQ 1
`define ASC_B_AUTO 2
`define ASC_B_PAR 3
`define ASC_TRIG_LO 5
`define ASC_TRIG_HI 7
`define ASC_FMT_LO 8
`define ASC_FMT_HI 9
`define ASC_B_WIDE 10
`define ASC_CHN_HI 1
`define ASC_RST_CTRL 16'h0000
`define ASC_RST_CHN 2'h0

// ----------------------------------------------------------------
// codes
// ----------------------------------------------------------------
`define ASC_TRIG_SW 3'h0
`define ASC_TRIG_PIN 3'h1
`define ASC_TRIG_TMR3 3'h2
`define ASC_TRIG_TMR5 3'h4
`define ASC_TRIG_AUTO 3'h7
`define ASC_FMT_INT 2'h0
`define ASC_FMT_SINT 2'h1
`define ASC_FMT_FRAC 2'h2
`define ASC_FMT_SFRAC 2'h3
`define ASC_CHN_ONE 2'h0
`define ASC_CHN_TWO 2'h1
`define ASC_LAST_ONE 2'h0
`define ASC_LAST_TWO 2'h1
`define ASC_LAST_FOUR 2'h3
`define ASC_AUTO_CYC 16

`endif

// [verif/adc_sample_convert_control_tb.sv]
/*
  Self-checking bench of the converter sequencing control.
  Assumes asc_regs.svh on the include path and the core model beside it.
*/
`timescale 1ns/10ps
`include "asc_regs.svh"
module adc_sample_convert_control_tb;
  import asc_pkg::*;
  localparam logic [11:0] RAW = 12'ha53;
  localparam logic [7:0] CT = `ASC_OFF_CTRL;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, slv_q;
  logic irq_zero_pin, tmr3_cmp, tmr5_cmp, slow, conv_done;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [11:0] conv_raw;
  logic [3:0] sample_mask;
  logic [15:0] result_word;
  asc_conv_s conv_req;
  int err_total = 0;
  int checks = 0;
  int cyc = 0;

  asc_ctrl #(.AUTO_CYC(3)) i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .irq_zero_pin, .tmr3_cmp, .tmr5_cmp, .conv_req, .conv_done,
    .conv_raw, .sample_mask, .result_word);
  asc_core_model #(.RAW(RAW)) i_core (.pclk, .presetn, .slow, .conv_req, .conv_done,
    .conv_raw);

  // ----------------------------------------------------------------
  // clock, hang guard, verdict
  // ----------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // the run needs a few hundred cycles; a stuck wait ends here
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total = err_total + 1;
      $display("mismatch at %0t: timeout", $time);
      complete_run();
    end
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks = checks + 1;
    if (got !== exp) begin
      err_total = err_total + 1;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // ----------------------------------------------------------------
  // bus and stimulus tasks
  // ----------------------------------------------------------------
  // one apb transfer; an idle edge first so psel is never set twice in a step
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    slv_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // control word: wide, layout, trigger, parallel, auto restart, acquire
  function automatic logic [31:0] ctl(input logic w, input logic [1:0] f,
                                      input logic [2:0] t, input logic p,
                                      input logic au, input logic acq);
    return {21'h00_0000, w, f, t, 1'b0, p, au, acq, 1'b0};
  endfunction

  // expected result word from the layout description
  function automatic logic [15:0] fexp(input logic w, input logic [1:0] f,
                                       input logic [11:0] r);
    if (!w) return {6'h00, r[9:0]};
    case (f)
      2'h0: return {4'h0, r};
      2'h1: return {{5{~r[11]}}, r[10:0]};
      2'h2: return {r, 4'h0};
      default: return {~r[11], r[10:0], 4'h0};
    endcase
  endfunction

  // polls the control register until the complete flag reads one
  task automatic wait_done();
    rd = 32'h0000_0000;
    while (rd[0] !== 1'b1) begin
      apb(1'b0, CT, 32'h0000_0000);
    end
  endtask

  // event sources held for three edges; the pin goes through a synchroniser
  task automatic fire(input logic [2:0] t);
    @(posedge pclk);
    irq_zero_pin <= (t == 3'h1);
    tmr3_cmp <= (t == 3'h2);
    tmr5_cmp <= (t == 3'h4);
    repeat (3) @(posedge pclk);
    {irq_zero_pin, tmr3_cmp, tmr5_cmp} <= 3'b000;
  endtask

  // one 12-bit single-channel conversion under trigger t and layout f
  task automatic convert(input logic [2:0] t, input logic [1:0] f);
    apb(1'b1, CT, ctl(1'b1, f, t, 1'b0, 1'b0, 1'b0));
    apb(1'b1, CT, ctl(1'b1, f, t, 1'b0, 1'b0, 1'b1));
    if (t != 3'h7) begin
      apb(1'b0, CT, 32'h0000_0000);
      cmp({31'h0, rd[1]}, 32'h1, "sampling");
      if (t == 3'h0) apb(1'b1, CT, ctl(1'b1, f, t, 1'b0, 1'b0, 1'b0));
      else fire(t);
    end
    wait_done();
    cmp({30'h0, rd[1:0]}, 32'h1, "done after trigger");
    cmp({16'h0000, result_word}, {16'h0000, fexp(1'b1, f, RAW)}, "result port");
    apb(1'b0, `ASC_OFF_RES, 32'h0000_0000);
    cmp(rd, {16'h0000, fexp(1'b1, f, RAW)}, "result layout");
  endtask

  // multi-channel run: mask while sampling, mask at first done, last result
  task automatic multi(input logic p, input logic [1:0] chn, input logic [3:0] ms,
                       input logic [3:0] mh);
    apb(1'b1, `ASC_OFF_CHAN, {30'h0, chn});
    apb(1'b1, CT, ctl(1'b0, 2'h0, 3'h0, p, 1'b0, 1'b1));
    @(posedge pclk);
    cmp({28'h0, sample_mask}, {28'h0, ms}, "mask sampling");
    apb(1'b1, CT, ctl(1'b0, 2'h0, 3'h0, p, 1'b0, 1'b0));
    while (conv_done !== 1'b1) begin
      @(posedge pclk);
    end
    cmp({28'h0, sample_mask}, {28'h0, mh}, "mask holding");
    wait_done();
    apb(1'b0, `ASC_OFF_RES, 32'h0000_0000);
    cmp(rd, {16'h0, fexp(1'b0, 2'h0, RAW + {10'h0, chn[1] ? 2'h3 : 2'h1})}, "last result");
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {presetn, psel, penable, pwrite, irq_zero_pin, tmr3_cmp, tmr5_cmp, slow} = 8'h00;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, CT, 32'h0000_0000);
    cmp(rd, 32'h0000_0000, "ctrl reset");
    apb(1'b0, 8'h0c, 32'h0000_0000);
    cmp({31'h0, slv_q}, 32'h1, "unmapped error");
    $display("test reset done");
    convert(3'h0, 2'h0);
    convert(3'h1, 2'h1);
    convert(3'h2, 2'h2);
    convert(3'h4, 2'h3);
    convert(3'h7, 2'h0);
    $display("test triggers done");
    slow <= 1'b1;
    apb(1'b1, CT, ctl(1'b1, 2'h0, 3'h0, 1'b0, 1'b0, 1'b1) | 32'h1);
    apb(1'b0, CT, 32'h0000_0000);
    cmp({30'h0, rd[1:0]}, 32'h3, "flag kept");
    apb(1'b1, CT, ctl(1'b1, 2'h0, 3'h0, 1'b0, 1'b0, 1'b0) | 32'h1);
    apb(1'b0, CT, 32'h0000_0000);
    cmp({30'h0, rd[1:0]}, 32'h0, "flag at start");
    wait_done();
    cmp({30'h0, rd[1:0]}, 32'h1, "flag at end");
    apb(1'b1, CT, ctl(1'b1, 2'h0, 3'h0, 1'b0, 1'b0, 1'b1));
    apb(1'b0, CT, 32'h0000_0000);
    cmp({30'h0, rd[1:0]}, 32'h2, "flag cleared");
    apb(1'b1, CT, ctl(1'b1, 2'h0, 3'h0, 1'b0, 1'b0, 1'b1) | 32'h1);
    apb(1'b0, CT, 32'h0000_0000);
    cmp({30'h0, rd[1:0]}, 32'h2, "flag not set");
    apb(1'b1, CT, ctl(1'b1, 2'h0, 3'h0, 1'b0, 1'b0, 1'b0));
    wait_done();
    cmp({30'h0, rd[1:0]}, 32'h1, "done after clear");
    slow <= 1'b0;
    $display("test flag done");
    apb(1'b1, CT, ctl(1'b1, 2'h0, 3'h0, 1'b0, 1'b1, 1'b0));
    apb(1'b0, CT, 32'h0000_0000);
    cmp({31'h0, rd[1]}, 32'h1, "auto sampling");
    apb(1'b1, CT, ctl(1'b1, 2'h0, 3'h0, 1'b0, 1'b1, 1'b0));
    wait_done();
    apb(1'b0, CT, 32'h0000_0000);
    cmp({31'h0, rd[1]}, 32'h1, "auto restart");
    apb(1'b1, CT, ctl(1'b1, 2'h0, 3'h0, 1'b0, 1'b0, 1'b0));
    wait_done();
    apb(1'b0, CT, 32'h0000_0000);
    cmp({30'h0, rd[1:0]}, 32'h1, "no restart");
    $display("test restart done");
    apb(1'b1, CT, ctl(1'b1, 2'h0, 3'h0, 1'b1, 1'b0, 1'b0));
    apb(1'b0, CT, 32'h0000_0000);
    cmp({31'h0, rd[3]}, 32'h0, "parallel wide");
    apb(1'b1, CT, ctl(1'b0, 2'h0, 3'h0, 1'b1, 1'b0, 1'b0));
    apb(1'b0, CT, 32'h0000_0000);
    cmp({31'h0, rd[3]}, 32'h1, "parallel narrow");
    multi(1'b1, 2'h3, 4'hf, 4'h0);
    multi(1'b1, 2'h1, 4'h3, 4'h0);
    multi(1'b0, 2'h3, 4'hf, 4'he);
    $display("test channels done");
    apb(1'b1, CT, ctl(1'b1, 2'h0, 3'h3, 1'b0, 1'b0, 1'b0));
    apb(1'b1, CT, ctl(1'b1, 2'h0, 3'h3, 1'b0, 1'b0, 1'b1));
    fire(3'h1);
    fire(3'h2);
    fire(3'h4);
    apb(1'b0, CT, 32'h0000_0000);
    cmp({31'h0, rd[1]}, 32'h1, "reserved trigger");
    apb(1'b1, CT, ctl(1'b1, 2'h0, 3'h0, 1'b0, 1'b0, 1'b1));
    apb(1'b1, CT, ctl(1'b1, 2'h0, 3'h0, 1'b0, 1'b0, 1'b0));
    wait_done();
    cmp({30'h0, rd[1:0]}, 32'h1, "done after reserved");
    $display("test reserved done");
    complete_run();
  end
endmodule

// [verif/asc_core_model.sv]
/*
  Behavioural analogue core beside the sequencer: answers each start
  pulse with a one-cycle done pulse and a raw code.
  Assumes the sequencer on the same pclk; slow stretches the latency.
*/
`timescale 1ns/10ps
module asc_core_model #(
  parameter logic [11:0] RAW = 12'ha53
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic slow,
  input asc_pkg::asc_conv_s conv_req,
  output logic conv_done,
  output logic [11:0] conv_raw
);
  import asc_pkg::*;
  logic [3:0] cnt_q;
  logic [11:0] code_q;

  // one conversion at a time; the code is the base plus the channel
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 4'h0;
      code_q <= 12'h000;
      conv_done <= 1'b0;
    end else begin
      conv_done <= (cnt_q == 4'h1);
      if (conv_req.start) begin
        cnt_q <= slow ? 4'h8 : 4'h1;
        code_q <= RAW + {10'h000, conv_req.chan};
      end else if (cnt_q != 4'h0) begin
        cnt_q <= cnt_q - 4'h1;
      end
    end
  end

  // the code is only valid with done; elsewhere its inverse, so a late sample shows
  assign conv_raw = conv_done ? code_q : ~code_q;
endmodule
